// ===== rtl/wdt_regs.svh
// register offsets, field positions, reset values and limits of the watchdog
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define WDT_OFS_CONTROL 4'h0
`define WDT_OFS_STATUS 4'h4
`define WDT_OFS_MASK 4'h8
`define WDT_OFS_FLAGS 4'hC

// ****************************************************************
// field positions
// ****************************************************************
`define WDT_EN_BIT 0
`define WDT_PS_LSB 1
`define WDT_PS_MSB 5
`define WDT_EV_RESET_BIT 0
`define WDT_EV_WAKE_BIT 1
`define WDT_EV_SLEEP_BIT 2
`define WDT_FLAG_PD_BIT 0
`define WDT_FLAG_TO_BIT 1
`define WDT_FLAG_ASLEEP_BIT 2

// ****************************************************************
// reset values and limits
// ****************************************************************
`define WDT_PS_RESET 5'h0B
`define WDT_EN_RESET 1'h0
`define WDT_PS_MAX 5'h12
`define WDT_MIN_DIV 24'h000020
`define WDT_EV_WIDTH 3
`define WDT_CNT_WIDTH 23

`endif

// ===== rtl/wdt_pkg.sv
// types shared by the watchdog block
// assumes the constants of wdt_regs.svh
package wdt_pkg;

    // ****************************************************************
    // watchdog operating mode from the configuration word
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_SW = 2'b01,
        MODE_AWAKE = 2'b10,
        MODE_ON = 2'b11
    } mode_e;

endpackage

// ===== rtl/watchdog_timer_block.sv
// watchdog timer with wishbone control/status registers
// assumes clk_i is the low-frequency internal oscillator and that all
// core-side strobes arrive already synchronised to it
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "wdt_regs.svh"

// Functional notes
// - awake time-out without clear resets device
// - counter runs on low-frequency oscillator clock
// - mode 11 always active, sleep included
// - mode 10 active awake, off asleep
// - mode 01 follows software enable bit
// - mode 00 off; enable ignored otherwise
// - period select: 32 doubled per code
// - reserved period codes use division 32
// - period select resets to two seconds
// - count cleared on listed clearing events
// - sleep entry clears, counting may continue
// - crystal wake holds clear until startup
// - sleep time-out wakes, no reset, flags
// - oscillator divider change leaves count alone
// - control bits 7:6 zero, enable resets 0
// - sleep entry clears pd, sets to
module watchdog_timer_block (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire wdt_pkg::mode_e watchdog_mode_config_i,
    input wire logic watchdog_clear_instruction_i,
    input wire logic sleep_enter_i,
    input wire logic sleep_exit_i,
    input wire logic osc_fail_i,
    input wire logic crystal_clock_i,
    input wire logic oscillator_startup_timer_running_i,
    output logic watchdog_reset_o,
    output logic wake_o,
    output logic watchdog_expired_flag_n_o,
    output logic sleep_entered_flag_n_o,
    output logic irq_o
);
    import wdt_pkg::*;

    // ****************************************************************
    // functions
    // ****************************************************************
    // terminal count for a period select code
    function automatic logic [`WDT_CNT_WIDTH-1:0] term_count(input logic [4:0] ps);
        logic [23:0] div;
        div = `WDT_MIN_DIV;
        if (ps <= `WDT_PS_MAX) begin
            div = `WDT_MIN_DIV << ps;
        end
        term_count = 23'(div - 24'h000001);
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic [4:0] period_select;
    logic software_watchdog_enable;
    logic [`WDT_EV_WIDTH-1:0] status;
    logic [`WDT_EV_WIDTH-1:0] mask;
    logic [`WDT_CNT_WIDTH-1:0] count;
    logic asleep;
    logic hold_startup;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    wire bus_rd = bus_req && !wb_we_i;
    wire sel_ctrl = wb_adr_i == `WDT_OFS_CONTROL;
    wire sel_stat = wb_adr_i == `WDT_OFS_STATUS;
    wire sel_mask = wb_adr_i == `WDT_OFS_MASK;
    wire sel_flag = wb_adr_i == `WDT_OFS_FLAGS;
    wire wr_ctrl = bus_wr && sel_ctrl;
    wire wr_mask = bus_wr && sel_mask;
    wire rd_stat = bus_rd && sel_stat;

    wire [7:0] ctrl_view = {2'b00, period_select, software_watchdog_enable};
    wire [2:0] flag_view = {asleep, watchdog_expired_flag_n_o, sleep_entered_flag_n_o};
    wire [31:0] rd_mux =
        sel_ctrl ? {24'h000000, ctrl_view} :
        sel_stat ? {29'h00000000, status} :
        sel_mask ? {29'h00000000, mask} :
        sel_flag ? {6'h00, count, flag_view} :
        32'h00000000;

    // ****************************************************************
    // mode decode
    // ****************************************************************
    wire mode_on = watchdog_mode_config_i == MODE_ON;
    wire mode_awake = watchdog_mode_config_i == MODE_AWAKE && !asleep;
    wire mode_sw = watchdog_mode_config_i == MODE_SW && software_watchdog_enable;
    wire active = mode_on || mode_awake || mode_sw;

    // ****************************************************************
    // clearing and time-out
    // ****************************************************************
    // no divider input exists, so a core clock change cannot touch count
    wire clear_any = watchdog_clear_instruction_i || sleep_enter_i || sleep_exit_i ||
        osc_fail_i || !active || oscillator_startup_timer_running_i || hold_startup;
    wire [`WDT_CNT_WIDTH-1:0] limit = term_count(period_select);
    wire expire = !clear_any && count == limit;
    wire expire_awake = expire && !asleep;
    wire expire_asleep = expire && asleep;
    wire [`WDT_EV_WIDTH-1:0] events = {sleep_enter_i, expire_asleep, expire_awake};
    wire [`WDT_EV_WIDTH-1:0] next_status = (rd_stat ? '0 : status) | events;
    wire [`WDT_CNT_WIDTH-1:0] next_count =
        (clear_any || expire) ? '0 : count + 23'h000001;

    // ****************************************************************
    // bus slave
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_rd ? rd_mux : 32'h00000000;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_select <= `WDT_PS_RESET;
            software_watchdog_enable <= `WDT_EN_RESET;
            mask <= '0;
        end else begin
            if (wr_ctrl) begin
                period_select <= wb_dat_i[`WDT_PS_MSB:`WDT_PS_LSB];
                software_watchdog_enable <= wb_dat_i[`WDT_EN_BIT];
            end
            if (wr_mask) begin
                mask <= wb_dat_i[`WDT_EV_WIDTH-1:0];
            end
        end
    end

    // set wins over read clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= '0;
            irq_o <= 1'b0;
        end else begin
            status <= next_status;
            irq_o <= |(next_status & mask);
        end
    end

    // ****************************************************************
    // counter, sleep tracking and pulses
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            asleep <= 1'b0;
        end else if (sleep_exit_i || expire_asleep) begin
            asleep <= 1'b0;
        end else if (sleep_enter_i) begin
            asleep <= 1'b1;
        end
    end

    // crystal wake: held clear until the startup timer has run
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_startup <= 1'b0;
        end else if (sleep_exit_i && crystal_clock_i) begin
            hold_startup <= 1'b1;
        end else if (!oscillator_startup_timer_running_i) begin
            hold_startup <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            watchdog_reset_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            watchdog_reset_o <= expire_awake;
            wake_o <= expire_asleep;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            watchdog_expired_flag_n_o <= 1'b1;
            sleep_entered_flag_n_o <= 1'b1;
        end else if (expire) begin
            watchdog_expired_flag_n_o <= 1'b0;
        end else if (sleep_enter_i) begin
            watchdog_expired_flag_n_o <= 1'b1;
            sleep_entered_flag_n_o <= 1'b0;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_reset_awake;
        expire && !asleep |=> watchdog_reset_o && !wake_o;
    endproperty
    a_reset_awake: assert property (p_reset_awake) else $error("awake time-out gave no reset");

    property p_wake_asleep;
        expire && asleep |=> wake_o && !watchdog_reset_o && !asleep && !watchdog_expired_flag_n_o;
    endproperty
    a_wake_asleep: assert property (p_wake_asleep) else $error("sleep time-out misbehaved");

    property p_always_on;
        watchdog_mode_config_i == MODE_ON && asleep && !clear_any && count == 23'h000003
            |=> count == 23'h000004;
    endproperty
    a_always_on: assert property (p_always_on) else $error("mode on stopped in sleep");

    property p_off_sleep;
        watchdog_mode_config_i == MODE_AWAKE && asleep |=> count == '0;
    endproperty
    a_off_sleep: assert property (p_off_sleep) else $error("mode awake counted in sleep");

    property p_sw_off;
        watchdog_mode_config_i == MODE_SW && !software_watchdog_enable |=> count == '0;
    endproperty
    a_sw_off: assert property (p_sw_off) else $error("software disable ignored");

    property p_mode_off;
        watchdog_mode_config_i == MODE_OFF ##1 watchdog_mode_config_i == MODE_OFF
            |-> count == '0 && !watchdog_reset_o;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("mode off counted");

    property p_reserved;
        period_select > `WDT_PS_MAX && !clear_any && count == 23'h00001F
            |=> count == '0 && (watchdog_reset_o || wake_o);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code not 1:32");

    property p_clear;
        watchdog_clear_instruction_i || osc_fail_i || sleep_exit_i |=> count == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear event missed");

    property p_sleep_entry;
        sleep_enter_i && !expire |=> count == '0 && !sleep_entered_flag_n_o &&
            watchdog_expired_flag_n_o && asleep;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry effects missing");

    property p_crystal_hold;
        sleep_exit_i && crystal_clock_i ##1 oscillator_startup_timer_running_i
            |=> count == '0;
    endproperty
    a_crystal_hold: assert property (p_crystal_hold) else $error("count moved during startup");

    property p_pulse;
        watchdog_reset_o |=> !watchdog_reset_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse too long");

    property p_ctrl_read;
        $rose(wb_ack_o) && !$past(wb_we_i) && $past(sel_ctrl)
            |-> wb_dat_o[7:6] == 2'b00 && wb_dat_o[5:1] == $past(period_select);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    property p_clear_wins;
        watchdog_clear_instruction_i && count == limit |=> count == '0 && !watchdog_reset_o && !wake_o;
    endproperty
    a_clear_wins: assert property (p_clear_wins) else $error("clear in terminal cycle lost");

    property p_wake_pulse;
        wake_o |=> !wake_o;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");

    property p_count_restart;
        watchdog_reset_o || wake_o |-> count == '0;
    endproperty
    a_count_restart: assert property (p_count_restart) else $error("count not restarted");

    property p_no_reset_asleep;
        asleep |=> !watchdog_reset_o;
    endproperty
    a_no_reset_asleep: assert property (p_no_reset_asleep) else $error("reset while asleep");

    property p_count_step;
        !clear_any && count != limit |=> count == $past(count) + 23'h000001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not step");

    property p_startup_clear;
        oscillator_startup_timer_running_i |=> count == '0;
    endproperty
    a_startup_clear: assert property (p_startup_clear) else $error("count moved during startup");

    property p_sw_on;
        watchdog_mode_config_i == MODE_SW && software_watchdog_enable && !clear_any && count == 23'h000001
            |=> count == 23'h000002;
    endproperty
    a_sw_on: assert property (p_sw_on) else $error("software enable not obeyed");

    property p_awake_on;
        watchdog_mode_config_i == MODE_AWAKE && !asleep && !clear_any && count == 23'h000001
            |=> count == 23'h000002;
    endproperty
    a_awake_on: assert property (p_awake_on) else $error("mode awake stopped while awake");

    property p_enable_ignored;
        watchdog_mode_config_i == MODE_OFF && software_watchdog_enable |=> count == '0;
    endproperty
    a_enable_ignored: assert property (p_enable_ignored) else $error("enable obeyed in mode off");

    property p_reserved_limit;
        period_select > `WDT_PS_MAX |-> limit == 23'h00001F;
    endproperty
    a_reserved_limit: assert property (p_reserved_limit) else $error("reserved code limit wrong");

    property p_reset_limit;
        period_select == `WDT_PS_RESET |-> limit == 23'h00FFFF;
    endproperty
    a_reset_limit: assert property (p_reset_limit) else $error("reset period limit wrong");

    property p_min_limit;
        period_select == 5'h00 |-> limit == 23'h00001F;
    endproperty
    a_min_limit: assert property (p_min_limit) else $error("minimum period limit wrong");

    property p_double_limit;
        period_select == 5'h01 |-> limit == 23'h00003F;
    endproperty
    a_double_limit: assert property (p_double_limit) else $error("period code 1 limit wrong");

    property p_ctrl_write;
        wr_ctrl |=> period_select == $past(wb_dat_i[`WDT_PS_MSB:`WDT_PS_LSB]) &&
            software_watchdog_enable == $past(wb_dat_i[`WDT_EN_BIT]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_pd_sticky;
        !sleep_entered_flag_n_o |=> !sleep_entered_flag_n_o;
    endproperty
    a_pd_sticky: assert property (p_pd_sticky) else $error("sleep flag returned early");

    property p_expired_flag;
        expire |=> !watchdog_expired_flag_n_o;
    endproperty
    a_expired_flag: assert property (p_expired_flag) else $error("time-out flag not set");

    property p_exit_clear;
        sleep_exit_i |=> !asleep && count == '0;
    endproperty
    a_exit_clear: assert property (p_exit_clear) else $error("sleep exit not taken");

endmodule

// ===== test/core_model.sv
// processor core model: clear, sleep entry and sleep exit strobes
// assumes the bench calls its tasks from one process only
`timescale 1ns/1ns
module core_model (
    input wire logic clk_i,
    output logic clear_o,
    output logic enter_o,
    output logic exit_o
);
    initial begin
        clear_o = 1'h0;
        enter_o = 1'h0;
        exit_o = 1'h0;
    end
    // one-cycle strobes; each task returns just after the sampling edge
    task automatic clear();
        @(posedge clk_i) clear_o <= 1'h1;
        @(posedge clk_i) clear_o <= 1'h0;
    endtask
    task automatic sleep();
        @(posedge clk_i) enter_o <= 1'h1;
        @(posedge clk_i) enter_o <= 1'h0;
    endtask
    task automatic wake();
        @(posedge clk_i) exit_o <= 1'h1;
        @(posedge clk_i) exit_o <= 1'h0;
    endtask
endmodule

// ===== test/tb_top.sv
// watchdog bench: register cases, table of mode rows, then clear, hold, sleep and reset cases
// assumes period codes 0 and 1 and the reserved codes (32, 64 and 32 cycles) keep every time-out short
`timescale 1ns/1ns
`include "wdt_regs.svh"
module tb_top;
    import wdt_pkg::*;
    typedef struct {mode_e m; logic [7:0] c; int e;} row_s;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0, osc = 1'h0, xtal = 1'h0, oscillator_startup_timer = 1'h0;
    logic [3:0] adr = 4'h0, sl = 4'hF;
    logic [31:0] dat = 32'h0, rdat, q;
    logic ack, rst_o, wake, to_n, pd_n, irq, clr, ent, ext;
    logic [1:0] kind;
    mode_e mode = MODE_ON;
    int err_count = 0, comparisons = 0, got;
    // time-out counts are period plus one, 81 means none
    row_s rows[8] = '{'{MODE_ON, 8'h00, 33}, '{MODE_AWAKE, 8'h00, 33}, '{MODE_SW, 8'h01, 33},
        '{MODE_SW, 8'h00, 81}, '{MODE_OFF, 8'h01, 81}, '{MODE_ON, 8'h02, 65},
        '{MODE_ON, 8'h26, 33}, '{MODE_ON, 8'h3E, 33}};
    always #5 clk_i = ~clk_i;
    watchdog_timer_block watchdog_timer_block_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sl), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .watchdog_mode_config_i(mode),
        .watchdog_clear_instruction_i(clr), .sleep_enter_i(ent), .sleep_exit_i(ext),
        .osc_fail_i(osc), .crystal_clock_i(xtal), .oscillator_startup_timer_running_i(oscillator_startup_timer),
        .watchdog_reset_o(rst_o), .wake_o(wake), .watchdog_expired_flag_n_o(to_n),
        .sleep_entered_flag_n_o(pd_n), .irq_o(irq));
    core_model core_model_i (.clk_i(clk_i), .clear_o(clr), .enter_o(ent), .exit_o(ext));
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("wrong value %s expected %0h seen %0h", n, e, g);
            err_count++;
        end
    endtask
    // classic single wishbone cycle; ack and read data taken at the rising edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 8);
        if (ack !== 1'h1) begin
            err_count++;
            conclude();
        end
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask
    // counts settled cycles until a reset or wake pulse, then checks it is one cycle
    task automatic tmo(input int lim);
        for (got = 1; got <= lim; got++) begin
            @(negedge clk_i);
            kind = {rst_o, wake};
            if (kind !== 2'h0) break;
        end
        if (got <= lim) begin
            @(negedge clk_i);
            chk("pulse end", 32'h0, {rst_o, wake});
        end
    endtask
    initial begin
        #500000;
        err_count++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, `WDT_OFS_CONTROL, 32'h0);
        chk("control reset", 32'h16, q);
        wb(1'h1, `WDT_OFS_CONTROL, 32'hFF);
        sl <= 4'h0;
        wb(1'h1, `WDT_OFS_CONTROL, 32'h0);
        sl <= 4'hF;
        wb(1'h0, `WDT_OFS_CONTROL, 32'h0);
        chk("control", 32'h3F, q);
        wb(1'h0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, q);
        foreach (rows[i]) begin
            wb(1'h1, `WDT_OFS_CONTROL, {24'h0, rows[i].c});
            mode <= rows[i].m;
            core_model_i.clear();
            tmo(80);
            chk("timeout", rows[i].e, got);
        end
        chk("irq masked", 32'h0, irq);
        wb(1'h1, `WDT_OFS_CONTROL, 32'h0);
        core_model_i.clear();
        repeat (20) @(posedge clk_i);
        core_model_i.clear();
        tmo(80);
        chk("clear restart", 33, got);
        core_model_i.clear();
        repeat (30) @(posedge clk_i);
        core_model_i.clear();
        tmo(80);
        chk("terminal clear", 33, got);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            osc <= (k == 0);
            oscillator_startup_timer <= (k == 1);
            tmo(50);
            chk("held clear", 51, got);
            @(posedge clk_i);
            osc <= 1'h0;
            oscillator_startup_timer <= 1'h0;
            tmo(80);
            chk("after hold", 33, got);
        end
        @(posedge clk_i);
        mode <= MODE_AWAKE;
        core_model_i.sleep();
        wb(1'h0, `WDT_OFS_FLAGS, 32'h0);
        chk("sleep flags", 32'h6, q & 32'h7);
        chk("pd pin", 32'h0, pd_n);
        chk("to pin", 32'h1, to_n);
        tmo(80);
        chk("asleep off", 81, got);
        core_model_i.wake();
        tmo(80);
        chk("exit", 33, got);
        wb(1'h0, `WDT_OFS_STATUS, 32'h0);
        wb(1'h1, `WDT_OFS_MASK, 32'h2);
        mode <= MODE_ON;
        core_model_i.sleep();
        tmo(80);
        chk("sleep timeout", 33, got);
        chk("wake kind", 32'h1, kind);
        chk("irq", 32'h1, irq);
        wb(1'h0, `WDT_OFS_FLAGS, 32'h0);
        chk("wake flags", 32'h0, q & 32'h7);
        chk("to pin wake", 32'h0, to_n);
        wb(1'h0, `WDT_OFS_STATUS, 32'h0);
        chk("status", 32'h6, q);
        chk("irq cleared", 32'h0, irq);
        mode <= MODE_AWAKE;
        core_model_i.sleep();
        oscillator_startup_timer <= 1'h1;
        xtal <= 1'h1;
        core_model_i.wake();
        tmo(50);
        chk("startup hold", 51, got);
        @(posedge clk_i);
        oscillator_startup_timer <= 1'h0;
        tmo(80);
        chk("startup end", 34, got);
        @(posedge clk_i);
        rst_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        @(negedge clk_i);
        chk("reset pd pin", 32'h1, pd_n);
        chk("reset to pin", 32'h1, to_n);
        chk("reset irq", 32'h0, irq);
        wb(1'h0, `WDT_OFS_CONTROL, 32'h0);
        chk("control after reset", 32'h16, q);
        wb(1'h0, `WDT_OFS_FLAGS, 32'h0);
        chk("flags after reset", 32'h3, q & 32'h7);
        conclude();
    end
endmodule
